// ### ffa_top.sv
// What this block does
// RULE_01: disabled setting shows no first-fault status and ignores all input changes.
// RULE_02: display-only setting shows status; a latched fail keeps burner run permission.
// RULE_03: enabled setting forces burner shutdown while a first fault stays latched.
// RULE_04: up to fifteen independently watched inputs, one per chain element.
// RULE_05: only the first input to open shows fail; later ones stay normal.
// RULE_06: first fail stays latched until reset, even when that input recovers.
// RULE_07: a thirty-character user title is stored for every watched input.
// RULE_08: any input going from normal to fail requests the status view.
// RULE_09: a setting selects manual-only or automatic clearing of the latched fail.
// RULE_10: installer wires each element's normally-open contact to its own input; the code treats a closed contact (voltage present) as normal.
// RULE_11: inputs are synchronised; on a tie the lowest-numbered input latches.
// RULE_12: automatic mode clears the latch once every input is normal again.
`default_nettype none
module ffa_top
   import ffa_pkg::*;
#(
   parameter int unsigned NUM_IN    = FFA_NUM_IN,
   parameter int unsigned TITLE_LEN = FFA_TITLE_LEN
) (
   input  wire logic                  clk_sys_i,          // system clock, 10 MHz
   input  wire logic                  srst_i,             // synchronous reset, high
   input  wire logic [NUM_IN-1:0]     alarm_input_i,      // chain taps, high = normal
   input  wire logic                  psel_i,             // apb select
   input  wire logic                  penable_i,          // apb access phase
   input  wire logic                  pwrite_i,           // apb direction
   input  wire logic [FFA_ADDR_W-1:0] paddr_i,            // apb byte address
   input  wire logic [FFA_DATA_W-1:0] pwdata_i,           // apb write data
   output logic      [FFA_DATA_W-1:0] prdata_o,           // apb read data
   output logic                       pready_o,           // apb ready
   output logic                       pslverr_o,          // apb error, unmapped
   output logic      [NUM_IN-1:0]     fail_status_o,      // shown fail flags
   output logic                       burner_shutdown_o,  // shutdown request
   output logic                       burner_run_ok_o,    // run permission
   output logic                       view_request_o,     // one pulse per new fail
   output logic                       irq_o               // level interrupt
);

   // ---------------------------------------------------------------
   // input synchronisation
   // ---------------------------------------------------------------
   logic [NUM_IN-1:0] in_sync;
   logic [NUM_IN-1:0] fail_now;

   // contacts come straight from the field, so two flops first
   ffa_sync #(
      .W   (NUM_IN),
      .RST ({NUM_IN{1'b1}})
   ) u_sync (
      .clk_sys_i (clk_sys_i),
      .srst_i    (srst_i),
      .async_i   (alarm_input_i),
      .sync_o    (in_sync)
   );

   // voltage removed on a tap means that element has opened
   assign fail_now = ~in_sync; // RULE_10

   // ---------------------------------------------------------------
   // register state
   // ---------------------------------------------------------------
   logic [1:0]            mode;
   logic [1:0]            next_mode;
   logic                  auto_clr;
   logic                  next_auto_clr;
   logic [FFA_INT_W-1:0]  int_stat;
   logic [FFA_INT_W-1:0]  next_int_stat;
   logic [FFA_INT_W-1:0]  int_mask;
   logic [FFA_INT_W-1:0]  next_int_mask;
   logic [FFA_IDX_W-1:0]  tsel_idx;
   logic [FFA_IDX_W-1:0]  next_tsel_idx;
   logic [FFA_CHR_W-1:0]  tsel_chr;
   logic [FFA_CHR_W-1:0]  next_tsel_chr;
   logic                  next_irq;

   // latch state
   ffa_state_e            state;
   ffa_state_e            next_state;
   logic [NUM_IN-1:0]     fail_stat;
   logic [NUM_IN-1:0]     next_fail_stat;
   logic [NUM_IN-1:0]     fail_prev;
   logic [NUM_IN-1:0]     next_fail_prev;
   logic [FFA_FIRST_W-1:0] first_num;
   logic [FFA_FIRST_W-1:0] next_first_num;
   logic [NUM_IN-1:0]     next_fail_out;
   logic                  next_shutdown;
   logic                  next_run_ok;
   logic                  next_view;

   // bus slave state
   logic [FFA_DATA_W-1:0] next_prdata;
   logic                  next_pready;
   logic                  next_pslverr;

   // decoded events and strobes
   ffa_apb_req_s          req;
   logic                  setup_ph;
   logic                  done;
   logic                  wr_ctrl;
   logic                  wr_int_stat;
   logic                  wr_int_mask;
   logic                  wr_tsel;
   logic                  wr_tdata;
   logic                  clr_cmd;
   logic                  mode_on;
   logic [NUM_IN-1:0]     new_fail;
   logic [NUM_IN-1:0]     pick;
   logic [FFA_FIRST_W-1:0] pick_num;
   logic                  ev_first;
   logic                  ev_view;
   logic [FFA_CHAR_W-1:0] title_rd;
   logic                  mapped;

   // ---------------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------------
   assign req.addr    = paddr_i;
   assign req.write   = pwrite_i;
   assign req.wdata   = pwdata_i;
   assign setup_ph    = psel_i & ~penable_i;
   // the write lands only at the edge that completes the access
   assign done        = psel_i & penable_i & pready_o;
   assign wr_ctrl     = done & req.write & (req.addr == FFA_OFS_CTRL);
   assign wr_int_stat = done & req.write & (req.addr == FFA_OFS_INT_STAT);
   assign wr_int_mask = done & req.write & (req.addr == FFA_OFS_INT_MASK);
   assign wr_tsel     = done & req.write & (req.addr == FFA_OFS_TSEL);
   assign wr_tdata    = done & req.write & (req.addr == FFA_OFS_TDATA);
   assign clr_cmd     = wr_ctrl & req.wdata[FFA_CTRL_CLR_BIT]; // RULE_09

   // reserved mode code 3 is treated as disabled
   assign mode_on = (mode == FFA_MODE_SHOW) || (mode == FFA_MODE_TRIP); // RULE_01

   // ---------------------------------------------------------------
   // title storage
   // ---------------------------------------------------------------
   ffa_title_store #(
      .NUM (NUM_IN),
      .LEN (TITLE_LEN)
   ) u_titles (
      .clk_sys_i (clk_sys_i),
      .srst_i    (srst_i),
      .wr_en_i   (wr_tdata), // RULE_07
      .wr_idx_i  (tsel_idx),
      .wr_chr_i  (tsel_chr),
      .wr_data_i (req.wdata[FFA_CHAR_W-1:0]),
      .rd_idx_i  (tsel_idx),
      .rd_chr_i  (tsel_chr),
      .rd_data_o (title_rd)
   );

   // ---------------------------------------------------------------
   // first-fault picking
   // ---------------------------------------------------------------
   // scan from the top so the lowest changing input wins a tie
   always_comb begin
      new_fail = fail_now & ~fail_prev;
      pick     = '0;
      pick_num = '0;
      for (int i = NUM_IN - 1; i >= 0; i--) begin
         if (new_fail[i]) begin
            pick     = '0;
            pick[i]  = 1'b1; // RULE_11
            pick_num = FFA_FIRST_W'(i + 1);
         end
      end
   end

   // ---------------------------------------------------------------
   // latch sequencer
   // ---------------------------------------------------------------
   // edges are tracked even while idle, so enabling never trips on an
   // element that was already open beforehand
   always_comb begin
      next_state     = state;
      next_fail_stat = fail_stat;
      next_first_num = first_num;
      next_fail_prev = fail_now;
      ev_first       = 1'b0;
      ev_view        = 1'b0;
      case (state)
         FFA_ST_IDLE: begin
            next_fail_stat = '0; // RULE_01
            next_first_num = '0;
            if (mode_on) begin
               next_state = FFA_ST_WATCH;
            end
         end
         FFA_ST_WATCH: begin
            if (!mode_on) begin
               next_state = FFA_ST_IDLE; // RULE_01
            end else if (|new_fail) begin
               next_state     = FFA_ST_LATCHED;
               next_fail_stat = pick; // RULE_05
               next_first_num = pick_num;
               ev_first       = 1'b1;
               ev_view        = 1'b1; // RULE_08
            end
         end
         FFA_ST_LATCHED: begin
            // later openings still ask for the view but never change the flags
            ev_view = mode_on & (|new_fail); // RULE_08
            if (!mode_on) begin
               next_state = FFA_ST_IDLE;
            end else if (clr_cmd || (auto_clr && !(|fail_now))) begin // RULE_09
               next_state     = FFA_ST_WATCH; // RULE_12
               next_fail_stat = '0;
               next_first_num = '0;
            end else begin
               next_fail_stat = fail_stat; // RULE_06
            end
         end
         default: begin
            next_state     = FFA_ST_IDLE;
            next_fail_stat = '0;
            next_first_num = '0;
         end
      endcase
   end

   // outputs follow the next state so they line up with the status flags
   always_comb begin
      next_fail_out = mode_on ? next_fail_stat : '0; // RULE_02
      next_shutdown = (next_state == FFA_ST_LATCHED) && (mode == FFA_MODE_TRIP); // RULE_03
      next_run_ok   = !next_shutdown; // RULE_02
      next_view     = ev_view;
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         state             <= FFA_ST_IDLE;
         fail_stat         <= '0;
         fail_prev         <= '0;
         first_num         <= '0;
         fail_status_o     <= '0;
         burner_shutdown_o <= 1'b0;
         burner_run_ok_o   <= 1'b1;
         view_request_o    <= 1'b0;
      end else begin
         state             <= next_state;
         fail_stat         <= next_fail_stat;
         fail_prev         <= next_fail_prev;
         first_num         <= next_first_num;
         fail_status_o     <= next_fail_out;
         burner_shutdown_o <= next_shutdown;
         burner_run_ok_o   <= next_run_ok;
         view_request_o    <= next_view;
      end
   end

   // ---------------------------------------------------------------
   // control, interrupt and title select registers
   // ---------------------------------------------------------------
   // a new event beats a write-one-to-clear in the same cycle
   always_comb begin
      next_mode     = mode;
      next_auto_clr = auto_clr;
      next_int_mask = int_mask;
      next_tsel_idx = tsel_idx;
      next_tsel_chr = tsel_chr;
      next_int_stat = int_stat;
      if (wr_ctrl) begin
         next_mode     = req.wdata[FFA_CTRL_MODE_LSB +: FFA_CTRL_MODE_W];
         next_auto_clr = req.wdata[FFA_CTRL_AUTO_BIT];
      end
      if (wr_int_mask) begin
         next_int_mask = req.wdata[FFA_INT_W-1:0];
      end
      if (wr_tsel) begin
         next_tsel_idx = req.wdata[FFA_TSEL_IDX_LSB +: FFA_IDX_W];
         next_tsel_chr = req.wdata[FFA_TSEL_CHR_LSB +: FFA_CHR_W];
      end
      if (wr_int_stat) begin
         next_int_stat = int_stat & ~req.wdata[FFA_INT_W-1:0];
      end
      next_int_stat[FFA_INT_FIRST_BIT] = next_int_stat[FFA_INT_FIRST_BIT] | ev_first;
      next_int_stat[FFA_INT_VIEW_BIT]  = next_int_stat[FFA_INT_VIEW_BIT] | ev_view;
      next_irq = |(next_int_stat & next_int_mask);
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         mode     <= FFA_MODE_RST;
         auto_clr <= FFA_AUTO_RST;
         int_mask <= FFA_INT_MASK_RST;
         int_stat <= '0;
         tsel_idx <= '0;
         tsel_chr <= '0;
         irq_o    <= 1'b0;
      end else begin
         mode     <= next_mode;
         auto_clr <= next_auto_clr;
         int_mask <= next_int_mask;
         int_stat <= next_int_stat;
         tsel_idx <= next_tsel_idx;
         tsel_chr <= next_tsel_chr;
         irq_o    <= next_irq;
      end
   end

   // ---------------------------------------------------------------
   // apb answer
   // ---------------------------------------------------------------
   // read data is captured in the setup cycle and ready rises for the
   // first access cycle: one cycle of latency keeps every output a flop
   always_comb begin
      next_prdata  = '0;
      next_pready  = setup_ph;
      mapped       = 1'b1;
      case (req.addr)
         FFA_OFS_CTRL: begin
            next_prdata[FFA_CTRL_MODE_LSB +: FFA_CTRL_MODE_W] = mode;
            next_prdata[FFA_CTRL_AUTO_BIT] = auto_clr;
         end
         FFA_OFS_STATUS: begin
            next_prdata[NUM_IN-1:0] = mode_on ? fail_stat : '0; // RULE_01
            next_prdata[FFA_STAT_LATCH_BIT] = (state == FFA_ST_LATCHED);
            next_prdata[FFA_STAT_FIRST_LSB +: FFA_FIRST_W] = first_num;
         end
         FFA_OFS_INPUTS: begin
            next_prdata[NUM_IN-1:0] = fail_now; // RULE_04
         end
         FFA_OFS_INT_STAT: begin
            next_prdata[FFA_INT_W-1:0] = int_stat;
         end
         FFA_OFS_INT_MASK: begin
            next_prdata[FFA_INT_W-1:0] = int_mask;
         end
         FFA_OFS_TSEL: begin
            next_prdata[FFA_TSEL_IDX_LSB +: FFA_IDX_W] = tsel_idx;
            next_prdata[FFA_TSEL_CHR_LSB +: FFA_CHR_W] = tsel_chr;
         end
         FFA_OFS_TDATA: begin
            next_prdata[FFA_CHAR_W-1:0] = title_rd; // RULE_07
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
      if (!setup_ph || req.write) begin
         next_prdata = '0;
      end
      next_pslverr = setup_ph & ~mapped;
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         prdata_o  <= '0;
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end else begin
         prdata_o  <= next_prdata;
         pready_o  <= next_pready;
         pslverr_o <= next_pslverr;
      end
   end

endmodule
`default_nettype wire

// ### ffa_pkg.sv
`default_nettype none
package ffa_pkg;

   // sizes of the monitored chain and of the title store
   localparam int unsigned FFA_NUM_IN    = 15;
   localparam int unsigned FFA_TITLE_LEN = 30;
   localparam int unsigned FFA_CHAR_W    = 8;
   localparam int unsigned FFA_IDX_W     = 4;
   localparam int unsigned FFA_CHR_W     = 5;
   localparam int unsigned FFA_FIRST_W   = 4;
   localparam int unsigned FFA_ADDR_W    = 12;
   localparam int unsigned FFA_DATA_W    = 32;
   localparam int unsigned FFA_INT_W     = 2;

   // register byte offsets
   localparam logic [11:0] FFA_OFS_CTRL     = 12'h000;
   localparam logic [11:0] FFA_OFS_STATUS   = 12'h004;
   localparam logic [11:0] FFA_OFS_INPUTS   = 12'h008;
   localparam logic [11:0] FFA_OFS_INT_STAT = 12'h00C;
   localparam logic [11:0] FFA_OFS_INT_MASK = 12'h010;
   localparam logic [11:0] FFA_OFS_TSEL     = 12'h014;
   localparam logic [11:0] FFA_OFS_TDATA    = 12'h018;

   // control fields
   localparam int unsigned FFA_CTRL_MODE_LSB = 0;
   localparam int unsigned FFA_CTRL_MODE_W   = 2;
   localparam int unsigned FFA_CTRL_AUTO_BIT = 2;
   localparam int unsigned FFA_CTRL_CLR_BIT  = 3;

   // status fields
   localparam int unsigned FFA_STAT_LATCH_BIT = 16;
   localparam int unsigned FFA_STAT_FIRST_LSB = 20;

   // title select fields
   localparam int unsigned FFA_TSEL_IDX_LSB = 0;
   localparam int unsigned FFA_TSEL_CHR_LSB = 8;

   // interrupt bits
   localparam int unsigned FFA_INT_FIRST_BIT = 0;
   localparam int unsigned FFA_INT_VIEW_BIT  = 1;

   // reset values
   localparam logic [1:0] FFA_MODE_RST     = 2'h0;
   localparam logic       FFA_AUTO_RST     = 1'b0;
   localparam logic [1:0] FFA_INT_MASK_RST = 2'h0;

   // annunciator settings; code 3 behaves as disabled
   typedef enum logic [1:0] {
      FFA_MODE_OFF  = 2'h0,
      FFA_MODE_SHOW = 2'h1,
      FFA_MODE_TRIP = 2'h2
   } ffa_mode_e;

   // latch sequencer
   typedef enum logic [2:0] {
      FFA_ST_IDLE    = 3'b001,
      FFA_ST_WATCH   = 3'b010,
      FFA_ST_LATCHED = 3'b100
   } ffa_state_e;

   // one apb request as seen by the slave
   typedef struct packed {
      logic [11:0] addr;
      logic        write;
      logic [31:0] wdata;
   } ffa_apb_req_s;

endpackage
`default_nettype wire

// ### ffa_sync.sv
`default_nettype none
module ffa_sync
   import ffa_pkg::*;
#(
   parameter int unsigned W   = 1,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic         clk_sys_i,   // system clock
   input  wire logic         srst_i,      // synchronous reset
   input  wire logic [W-1:0] async_i,     // level from outside the domain
   output logic      [W-1:0] sync_o       // level after two flops
);

   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_sync;

   // first stage feeds only the second stage
   always_comb begin
      next_meta = async_i;
      next_sync = meta;
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         meta   <= RST;
         sync_o <= RST;
      end else begin
         meta   <= next_meta;
         sync_o <= next_sync;
      end
   end

endmodule
`default_nettype wire

// ### ffa_title_store.sv
`default_nettype none
module ffa_title_store
   import ffa_pkg::*;
#(
   parameter int unsigned NUM = FFA_NUM_IN,
   parameter int unsigned LEN = FFA_TITLE_LEN
) (
   input  wire logic                  clk_sys_i,  // system clock
   input  wire logic                  srst_i,     // synchronous reset
   input  wire logic                  wr_en_i,    // write one character
   input  wire logic [FFA_IDX_W-1:0]  wr_idx_i,   // input number, zero based
   input  wire logic [FFA_CHR_W-1:0]  wr_chr_i,   // character position
   input  wire logic [FFA_CHAR_W-1:0] wr_data_i,  // character code
   input  wire logic [FFA_IDX_W-1:0]  rd_idx_i,   // read input number
   input  wire logic [FFA_CHR_W-1:0]  rd_chr_i,   // read character position
   output logic      [FFA_CHAR_W-1:0] rd_data_o   // character, zero out of range
);

   logic [FFA_CHAR_W-1:0] mem [NUM][LEN];
   logic [FFA_CHAR_W-1:0] next_mem [NUM][LEN];

   // one byte per character, blank titles read as zero
   always_comb begin
      next_mem = mem;
      if (wr_en_i && (32'(wr_idx_i) < NUM) && (32'(wr_chr_i) < LEN)) begin
         next_mem[wr_idx_i][wr_chr_i] = wr_data_i;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         for (int i = 0; i < NUM; i++) begin
            for (int j = 0; j < LEN; j++) begin
               mem[i][j] <= '0;
            end
         end
      end else begin
         mem <= next_mem;
      end
   end

   // read stays combinational; the bus slave registers it
   always_comb begin
      rd_data_o = '0;
      if ((32'(rd_idx_i) < NUM) && (32'(rd_chr_i) < LEN)) begin
         rd_data_o = mem[rd_idx_i][rd_chr_i];
      end
   end

endmodule
`default_nettype wire

// ### ffa_props.sv
`default_nettype none
module ffa_props
   import ffa_pkg::*;
#(
   parameter int unsigned NUM_IN = FFA_NUM_IN
) (
   input wire logic                  clk_sys_i,         // clock
   input wire logic                  srst_i,            // reset
   input wire logic [NUM_IN-1:0]     alarm_input_i,     // chain taps
   input wire logic                  psel_i,            // apb select
   input wire logic                  penable_i,         // apb enable
   input wire logic                  pwrite_i,          // apb direction
   input wire logic [FFA_ADDR_W-1:0] paddr_i,           // apb address
   input wire logic [FFA_DATA_W-1:0] pwdata_i,          // apb data
   input wire logic                  pready_o,          // apb ready
   input wire logic [NUM_IN-1:0]     fail_status_o,     // fail flags
   input wire logic                  burner_shutdown_o, // shutdown
   input wire logic                  burner_run_ok_o,   // run permission
   input wire logic                  view_request_o     // view pulse
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);
   logic       ctrl_wr;
   logic       on_q;
   logic [1:0] mode_q;
   logic [1:0] next_mode;
   logic       auto_q;
   logic       next_auto;
   // shadow of the setting, so rules can be gated without seeing inside
   assign ctrl_wr = psel_i && penable_i && pready_o && pwrite_i && paddr_i == FFA_OFS_CTRL;
   assign on_q    = mode_q == FFA_MODE_SHOW || mode_q == FFA_MODE_TRIP;
   always_comb begin
      next_mode = ctrl_wr ? pwdata_i[1:0] : mode_q;
      next_auto = ctrl_wr ? pwdata_i[FFA_CTRL_AUTO_BIT] : auto_q;
      if (srst_i) begin
         next_mode = FFA_MODE_RST;
         next_auto = FFA_AUTO_RST;
      end
   end
   always_ff @(posedge clk_sys_i) begin
      mode_q <= next_mode;
      auto_q <= next_auto;
   end
   // steps of a fail event and of a recovered chain
   sequence s_new_fail;
      on_q && ((~alarm_input_i & $past(alarm_input_i)) != '0);
   endsequence
   sequence s_all_normal;
      (&alarm_input_i)[*3];
   endsequence
   a_run_ok_inverse: assert property (burner_run_ok_o == !burner_shutdown_o)
      else $error("run permission not inverse of shutdown");
   a_fail_onehot: assert property ($onehot0(fail_status_o))
      else $error("more than one input shows fail");
   a_view_on_fail: assert property (s_new_fail |-> ##[2:4] view_request_o)
      else $error("no view request after a new fail");
   a_trip_needs_latch: assert property (burner_shutdown_o |-> fail_status_o != '0)
      else $error("shutdown without a latched fail");
   a_trip_shuts: assert property (mode_q == FFA_MODE_TRIP && $past(mode_q) == FFA_MODE_TRIP
      && fail_status_o != '0 |-> burner_shutdown_o)
      else $error("latched fail did not shut burner down");
   a_show_runs: assert property (mode_q == FFA_MODE_SHOW && $past(mode_q) == FFA_MODE_SHOW
      |-> burner_run_ok_o)
      else $error("display setting withdrew run permission");
   a_off_quiet: assert property (!on_q && !$past(on_q)
      |-> fail_status_o == '0 && !view_request_o)
      else $error("disabled setting shows status or events");
   a_latch_holds: assert property (fail_status_o != '0 && !auto_q && !ctrl_wr
      && !$past(ctrl_wr) && !$past(ctrl_wr, 2) |=> $stable(fail_status_o))
      else $error("latched fail changed without reset");
   a_auto_clear: assert property ((auto_q && fail_status_o != '0) ##0 s_all_normal
      |-> ##[0:3] fail_status_o == '0)
      else $error("automatic reset did not clear the latch");
   a_fail_from_low: assert property ($rose(|fail_status_o)
      |-> (fail_status_o & $past(alarm_input_i, 2)) == '0)
      else $error("fail flag on an input that did not open");
endmodule
bind ffa_top ffa_props #(.NUM_IN(NUM_IN)) u_props (.clk_sys_i, .srst_i, .alarm_input_i,
   .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .fail_status_o,
   .burner_shutdown_o, .burner_run_ok_o, .view_request_o);
`default_nettype wire

// ### ffa_chain_model.sv
`default_nettype none
module ffa_chain_model
   import ffa_pkg::*;
(
   input  wire logic [FFA_NUM_IN-1:0] open_i, // elements whose contact has opened
   output logic      [FFA_NUM_IN-1:0] tap_o   // voltage seen at each input
);
   timeunit 1ns;
   timeprecision 1ns;
   // each element's own contact feeds its own input; open drops the voltage
   assign tap_o = ~open_i;
endmodule
`default_nettype wire

// ### ffa_top_tb.sv
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
   $display("BAD %s exp %h got %h", n, e, g); end end
module ffa_top_tb
   import ffa_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic                  clk_sys_i = 1'b0;
   logic                  srst_i;
   logic [FFA_NUM_IN-1:0] open_q;
   wire logic [14:0]      taps;
   logic                  psel;
   logic                  penable;
   logic                  pwrite;
   logic [11:0]           paddr;
   logic [31:0]           pwdata;
   logic [31:0]           prdata;
   logic                  pready;
   logic                  pslverr;
   logic [14:0]           fails;
   logic                  shut;
   logic                  run_ok;
   logic                  view;
   logic                  irq;
   logic [31:0]           rd;
   logic                  er;
   logic                  v;
   int                    errors = 0;
   int                    num_checks = 0;
   // 10 MHz system clock
   always #50 clk_sys_i = ~clk_sys_i;
   ffa_chain_model chain (.open_i(open_q), .tap_o(taps));
   ffa_top dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .alarm_input_i(taps), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .fail_status_o(fails),
      .burner_shutdown_o(shut), .burner_run_ok_o(run_ok), .view_request_o(view), .irq_o(irq));
   task automatic print_verdict();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // one apb transfer; an idle edge after it keeps drivers from double assignment
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys_i);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         errors++;
         print_verdict();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys_i);
   endtask
   // change the chain, then let sync and latch settle while catching the view pulse
   task automatic chain_set(input logic [14:0] o);
      open_q <= o;
      v = 1'b0;
      repeat (6) begin
         @(posedge clk_sys_i);
         if (view === 1'b1) v = 1'b1;
      end
   endtask
   task automatic s_off();
      for (int m = 0; m < 4; m += 3) begin
         apb(FFA_OFS_CTRL, 1'b1, 32'(m));
         chain_set(15'h0008);
         `CHK("off fail", 15'h0000, fails)
         `CHK("off view", 1'b0, v)
         apb(FFA_OFS_STATUS, 1'b0, 32'h0000_0000);
         `CHK("off status", 32'h0000_0000, rd)
         chain_set(15'h0000);
      end
   endtask
   task automatic s_trip();
      apb(FFA_OFS_INT_MASK, 1'b1, 32'h0000_0001);
      apb(FFA_OFS_CTRL, 1'b1, 32'(FFA_MODE_TRIP));
      chain_set(15'h0024);
      `CHK("tie", 15'h0004, fails)
      `CHK("shutdown", 1'b1, shut)
      `CHK("view", 1'b1, v)
      `CHK("irq on", 1'b1, irq)
      apb(FFA_OFS_STATUS, 1'b0, 32'h0000_0000);
      `CHK("status", 32'h0031_0004, rd)
      chain_set(15'h00A4);
      `CHK("later", 15'h0004, fails)
      `CHK("later view", 1'b1, v)
      chain_set(15'h0000);
      `CHK("held", 15'h0004, fails)
      `CHK("held shut", 1'b1, shut)
      apb(FFA_OFS_INT_MASK, 1'b1, 32'h0000_0000);
      @(posedge clk_sys_i);
      `CHK("irq masked", 1'b0, irq)
      apb(FFA_OFS_INT_STAT, 1'b1, 32'h0000_0003);
      apb(FFA_OFS_INT_MASK, 1'b1, 32'h0000_0003);
      @(posedge clk_sys_i);
      `CHK("irq cleared", 1'b0, irq)
      apb(FFA_OFS_CTRL, 1'b1, 32'(FFA_MODE_TRIP) | 32'h0000_0008);
      repeat (2) @(posedge clk_sys_i);
      `CHK("manual clr", 15'h0000, fails)
      `CHK("run again", 1'b1, run_ok)
   endtask
   task automatic s_show();
      apb(FFA_OFS_CTRL, 1'b1, 32'(FFA_MODE_SHOW));
      chain_set(15'h0001);
      `CHK("show fail", 15'h0001, fails)
      `CHK("show run", 1'b1, run_ok)
      chain_set(15'h0000);
      apb(FFA_OFS_CTRL, 1'b1, 32'(FFA_MODE_SHOW) | 32'h0000_0008);
   endtask
   task automatic s_auto();
      apb(FFA_OFS_CTRL, 1'b1, 32'(FFA_MODE_SHOW) | 32'h0000_0004);
      chain_set(15'h4000);
      `CHK("top input", 15'h4000, fails)
      apb(FFA_OFS_STATUS, 1'b0, 32'h0000_0000);
      `CHK("top status", 32'h00F1_4000, rd)
      chain_set(15'h0000);
      `CHK("auto clr", 15'h0000, fails)
   endtask
   task automatic s_title();
      logic [31:0] sel [3] = '{32'h0000_0000, 32'h0000_1D0E, 32'h0000_1E00};
      logic [7:0]  chr [3] = '{8'h77, 8'h76, 8'h00};
      for (int i = 0; i < 3; i++) begin
         apb(FFA_OFS_TSEL, 1'b1, sel[i]);
         apb(FFA_OFS_TDATA, 1'b1, 32'h0000_0077 - 32'(i));
      end
      for (int i = 0; i < 3; i++) begin
         apb(FFA_OFS_TSEL, 1'b1, sel[i]);
         apb(FFA_OFS_TDATA, 1'b0, 32'h0000_0000);
         `CHK("title", {24'h00_0000, chr[i]}, rd)
      end
   endtask
   initial begin
      srst_i = 1'b1;
      open_q = '0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      repeat (20) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      @(posedge clk_sys_i);
      `CHK("rst run", 1'b1, run_ok)
      apb(FFA_OFS_CTRL, 1'b0, 32'h0000_0000);
      `CHK("ctrl rst", 32'h0000_0000, rd)
      apb(12'h0FC, 1'b0, 32'h0000_0000);
      `CHK("unmapped", 1'b1, er)
      s_off();
      s_trip();
      s_show();
      s_auto();
      s_title();
      print_verdict();
   end
endmodule
`default_nettype wire
